// [xcc_top.sv]
// xcc_top: control, status, flush sequencing and performance counting for an
// execute-in-place flash cache, with an apb register slave.
// assumes: tag ram, data ram, flash path and stream engine sit outside on CLK;
// tag hit is valid combinationally in the cycle an xip access is offered.
//
// Behaviour
// RL1: both performance counters are 32 bits and stick at all ones.
// RL2: any write to a counter clears it to zero, or to one if that counter also counts in the same cycle.
// RL3: access counter counts every xip read through any flash alias, not writes.
// RL4: hit counter counts every access served from cached data.
// RL5: registers sit at base 0x14000000, eight words at offsets 0x00 to 0x1c.
// RL6: power-down bit powers cache memories down; contents kept, no access. A flush still clears tags (TAG_CLR_EN) while powered down.
// RL7: writing power-down as one forces the enable bit to zero.
// RL8: sram alias access while powered down ends with bus error.
// RL9: with bad-write fault set, writes outside caching-allocating alias fault.
// RL10: with bad-write fault clear, such writes complete and do nothing.
// RL11: writes to caching-allocating alias invalidate a matching entry only while the cache is enabled.
// RL12: cache disabled means every xip read through a flash alias goes to flash without lookup.
// RL13: enabled cacheable accesses look up and skip flash on valid hit.
// RL14: enabled cache makes sram alias accesses error, data memory untouched.
// RL15: writing one to invalidate bit starts a tag-only flush; bit self-clears.
// RL16: flush and reset never touch data memory contents.
// RL17: reading invalidate register stalls apb until the flush is done.
// RL18: software may instead poll the flush-ready status bit.
// RL19: flush steps an index through all 1024 sets, just over 1024 cycles.
// RL20: flush-ready reads zero during a flush; a flush runs out of reset.
`timescale 1ns/1ps
module xcc_top
  import xcc_pkg::*;
(
  // clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RSTN,
  // apb slave
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [31:0]            PADDR,
  input  wire logic [31:0]            PWDATA,
  output logic [31:0]                 PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  // xip access offer from the bus side
  input  wire logic                   XIP_VALID,
  input  wire logic                   XIP_WRITE,
  input  wire logic [2:0]             XIP_ALIAS,
  input  wire logic                   XIP_TAG_HIT,
  output logic                        XIP_READY,
  output logic                        XIP_ERR,
  // routing of the accepted access
  output logic                        CACHE_LOOKUP,
  output logic                        CACHE_INVAL,
  output logic                        FLASH_READ,
  output logic                        SRAM_ACCESS,
  // cache memory control
  output logic                        MEM_POWER_DOWN,
  output logic                        TAG_CLR_EN,
  output logic [FLUSH_IDX_W-1:0]      TAG_CLR_INDEX,
  // stream engine side
  output logic [31:0]                 STREAM_START_ADDR,
  output logic [STREAM_CNT_W-1:0]     STREAM_WORD_COUNT,
  output logic                        STREAM_COUNT_WR,
  output logic                        STREAM_QUEUE_POP,
  input  wire logic [31:0]            STREAM_QUEUE_DATA,
  input  wire logic                   STREAM_QUEUE_EMPTY,
  input  wire logic                   STREAM_QUEUE_FULL
);

  // ==========================================================================
  // apb decode
  logic                 in_window;
  logic [XCC_OFS_W-1:0] ofs;
  logic                 setup_ph;
  logic                 access_ph;
  logic                 wr_take;
  logic                 rd_take;
  logic                 flush_busy;

  assign in_window = PADDR[31:XCC_OFS_W] == XCC_BASE_ADDR[31:XCC_OFS_W]; // see RL5
  assign ofs       = PADDR[XCC_OFS_W-1:0];
  assign setup_ph  = PSEL && !PENABLE;
  assign access_ph = PSEL && PENABLE;

  // unaligned or out-of-window addresses are refused
  logic mapped;
  assign mapped = in_window && (ofs inside {OFS_CONTROL, OFS_INVALIDATE, OFS_STATUS,
                  OFS_HIT_CNT, OFS_ACC_CNT, OFS_STREAM_ADDR, OFS_STREAM_CNT, OFS_STREAM_QUEUE});

  // only a read of the invalidate register waits for the flush
  assign PREADY  = !(access_ph && !PWRITE && mapped && ofs == OFS_INVALIDATE
                     && flush_busy);                      // see RL17
  assign PSLVERR = access_ph && !mapped;                  // see RL5
  assign wr_take = access_ph && PWRITE && PREADY && mapped;
  assign rd_take = access_ph && !PWRITE && PREADY && mapped;

  // ==========================================================================
  // control register
  logic en_q;
  logic en_d;
  logic badwr_q;
  logic badwr_d;
  logic pd_q;
  logic pd_d;

  always_comb begin
    en_d    = en_q;
    badwr_d = badwr_q;
    pd_d    = pd_q;
    if (wr_take && ofs == OFS_CONTROL) begin
      pd_d    = PWDATA[CTL_PD_BIT];                       // see RL6
      badwr_d = PWDATA[CTL_BADWR_BIT];
      en_d    = PWDATA[CTL_EN_BIT] && !PWDATA[CTL_PD_BIT]; // see RL7
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      en_q    <= CTL_EN_RST;
      badwr_q <= CTL_BADWR_RST;
      pd_q    <= CTL_PD_RST;
    end else begin
      en_q    <= en_d;
      badwr_q <= badwr_d;
      pd_q    <= pd_d;
    end
  end

  assign MEM_POWER_DOWN = pd_q;                           // see RL6

  // ==========================================================================
  // flush sequencer: clears tag sets only, data memory has no port here
  xcc_flush_t               fl_state_q;
  xcc_flush_t               fl_state_d;
  logic [FLUSH_IDX_W-1:0]   fl_idx_q;
  logic [FLUSH_IDX_W-1:0]   fl_idx_d;
  logic                     fl_start;

  assign fl_start = wr_take && ofs == OFS_INVALIDATE && PWDATA[INV_GO_BIT]; // see RL15

  always_comb begin
    fl_state_d = fl_state_q;
    fl_idx_d   = fl_idx_q;
    unique case (fl_state_q)
      FL_IDLE: fl_idx_d = FLUSH_IDX_RST;
      FL_CLEAR: begin
        if (fl_idx_q == FLUSH_IDX_LAST) begin
          fl_state_d = FL_DONE;                           // see RL19
        end else begin
          fl_idx_d = fl_idx_q + FLUSH_IDX_W'(1);          // see RL19
        end
      end
      FL_DONE: begin
        fl_state_d = FL_IDLE;
        fl_idx_d   = FLUSH_IDX_RST;
      end
      default: begin
        fl_state_d = FL_IDLE;
        fl_idx_d   = FLUSH_IDX_RST;
      end
    endcase
    // a new request restarts the sweep from set zero
    if (fl_start) begin
      fl_state_d = FL_CLEAR;                              // see RL15
      fl_idx_d   = FLUSH_IDX_RST;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fl_state_q <= FL_CLEAR;                             // see RL20
      fl_idx_q   <= FLUSH_IDX_RST;
    end else begin
      fl_state_q <= fl_state_d;
      fl_idx_q   <= fl_idx_d;
    end
  end

  assign flush_busy    = fl_state_q != FL_IDLE;
  assign TAG_CLR_EN    = fl_state_q == FL_CLEAR;          // see RL16
  assign TAG_CLR_INDEX = fl_idx_q;

  // ==========================================================================
  // xip access routing; every alias is stalled while a flush runs
  logic acc_take;
  logic is_flash;
  logic is_cacheable;
  logic is_sram;
  logic hit;

  assign XIP_READY    = !flush_busy;
  assign acc_take     = XIP_VALID && XIP_READY;
  assign is_cacheable = XIP_ALIAS == ALIAS_CACHE_ALLOC || XIP_ALIAS == ALIAS_CACHE_NOALLOC;
  assign is_flash     = is_cacheable || XIP_ALIAS == ALIAS_NOCACHE_ALLOC
                        || XIP_ALIAS == ALIAS_NOCACHE_NOAL;
  assign is_sram      = XIP_ALIAS == ALIAS_SRAM;

  always_comb begin
    CACHE_LOOKUP = 1'b0;
    CACHE_INVAL  = 1'b0;
    FLASH_READ   = 1'b0;
    SRAM_ACCESS  = 1'b0;
    XIP_ERR      = 1'b0;
    hit          = 1'b0;
    if (acc_take) begin
      if (is_sram) begin
        // sram alias only works with the cache off and powered
        SRAM_ACCESS = !en_q && !pd_q;                     // see RL14
        XIP_ERR     = en_q || pd_q;                       // see RL8
      end else if (!is_flash) begin
        XIP_ERR = 1'b1;
      end else if (XIP_WRITE) begin
        if (XIP_ALIAS == ALIAS_CACHE_ALLOC) begin
          CACHE_INVAL = en_q;                             // see RL11
        end else begin
          XIP_ERR = badwr_q;                              // see RL9 RL10
        end
      end else begin
        CACHE_LOOKUP = en_q && is_cacheable;              // see RL12 RL13
        hit          = CACHE_LOOKUP && XIP_TAG_HIT;       // see RL13
        FLASH_READ   = !hit;                              // see RL12 RL13
      end
    end
  end

  // ==========================================================================
  // performance counters
  logic [CNT_W-1:0] hit_cnt;
  logic [CNT_W-1:0] acc_cnt;
  logic             acc_inc;

  assign acc_inc = acc_take && !XIP_WRITE && is_flash;    // see RL3

  xcc_sat_counter u_hit_cnt (
    .clk   (CLK),
    .rst_n (RSTN),
    .inc   (hit),                                         // see RL4
    .clr   (wr_take && ofs == OFS_HIT_CNT),               // see RL2
    .value (hit_cnt)
  );

  xcc_sat_counter u_acc_cnt (
    .clk   (CLK),
    .rst_n (RSTN),
    .inc   (acc_inc),
    .clr   (wr_take && ofs == OFS_ACC_CNT),               // see RL2
    .value (acc_cnt)
  );

  // ==========================================================================
  // stream registers, held here for the stream engine
  logic [29:0]             saddr_q;
  logic [29:0]             saddr_d;
  logic [STREAM_CNT_W-1:0] scnt_q;
  logic [STREAM_CNT_W-1:0] scnt_d;

  always_comb begin
    saddr_d = saddr_q;
    scnt_d  = scnt_q;
    if (wr_take && ofs == OFS_STREAM_ADDR) begin
      saddr_d = PWDATA[31:STREAM_ADDR_LSB];
    end
    if (wr_take && ofs == OFS_STREAM_CNT) begin
      scnt_d = PWDATA[STREAM_CNT_W-1:0];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      saddr_q <= STREAM_ADDR_RST;
      scnt_q  <= STREAM_CNT_RST;
    end else begin
      saddr_q <= saddr_d;
      scnt_q  <= scnt_d;
    end
  end

  assign STREAM_START_ADDR = {saddr_q, 2'b00};
  assign STREAM_WORD_COUNT = scnt_q;
  assign STREAM_COUNT_WR   = wr_take && ofs == OFS_STREAM_CNT;
  assign STREAM_QUEUE_POP  = rd_take && ofs == OFS_STREAM_QUEUE;

  // ==========================================================================
  // read data, captured in the setup phase and held through the access phase
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] rmux;

  always_comb begin
    rmux = 32'h0000_0000;
    unique case (ofs)
      OFS_CONTROL: begin
        rmux[CTL_EN_BIT]    = en_q;
        rmux[CTL_BADWR_BIT] = badwr_q;
        rmux[CTL_PD_BIT]    = pd_q;
      end
      OFS_STATUS: begin
        rmux[STS_READY_BIT] = !flush_busy;                // see RL20 RL18
        rmux[STS_EMPTY_BIT] = STREAM_QUEUE_EMPTY;
        rmux[STS_FULL_BIT]  = STREAM_QUEUE_FULL;
      end
      OFS_HIT_CNT:      rmux = hit_cnt;
      OFS_ACC_CNT:      rmux = acc_cnt;
      OFS_STREAM_ADDR:  rmux = {saddr_q, 2'b00};
      OFS_STREAM_CNT:   rmux = {{(32-STREAM_CNT_W){1'b0}}, scnt_q};
      OFS_STREAM_QUEUE: rmux = STREAM_QUEUE_DATA;
      default:          rmux = 32'h0000_0000;
    endcase
    rdata_d = rdata_q;
    if (setup_ph && !PWRITE) begin
      rdata_d = (mapped) ? rmux : 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign PRDATA = rdata_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_sweep_last;
    fl_state_q == FL_CLEAR && fl_idx_q == FLUSH_IDX_LAST && !fl_start;
  endsequence
  sequence s_sweep_finish;
    fl_state_q == FL_DONE ##1 fl_state_q == FL_IDLE;
  endsequence
  // a restart in the done cycle is legal, so only an unbroken tail is held
  a_flush_tail: assert property (s_sweep_last ##1 !fl_start |-> s_sweep_finish) // see RL19
    else $error("flush did not finish after the last set");
  a_flush_walk: assert property (                          // see RL19
    (fl_state_q == FL_CLEAR && fl_idx_q != FLUSH_IDX_LAST && !fl_start)
    |=> TAG_CLR_EN && fl_idx_q == $past(fl_idx_q) + FLUSH_IDX_W'(1))
    else $error("flush index did not step");
  a_flush_begin: assert property (fl_start |=> TAG_CLR_EN && fl_idx_q == FLUSH_IDX_RST
    && !XIP_READY)                                          // see RL15
    else $error("flush did not start at set zero");
  a_flush_stall: assert property (                         // see RL17
    (access_ph && !PWRITE && ofs == OFS_INVALIDATE && in_window) |-> PREADY == !flush_busy)
    else $error("invalidate read not stalled by flush");
  a_ready_status: assert property (                        // see RL20
    (setup_ph && !PWRITE && in_window && ofs == OFS_STATUS)
    |=> PRDATA[STS_READY_BIT] == $past(!flush_busy))
    else $error("flush ready status wrong");
  a_pd_forces_en: assert property (                        // see RL7
    (wr_take && ofs == OFS_CONTROL && PWDATA[CTL_PD_BIT]) |=> (!en_q && pd_q))
    else $error("enable survived a power-down write");
  a_sram_error: assert property (                          // see RL8
    (acc_take && is_sram && (pd_q || en_q)) |-> XIP_ERR && !SRAM_ACCESS)
    else $error("sram alias not refused");
  a_badwrite_err: assert property (                        // see RL9
    (acc_take && XIP_WRITE && is_flash && XIP_ALIAS != ALIAS_CACHE_ALLOC)
    |-> XIP_ERR == badwr_q && !FLASH_READ && !CACHE_INVAL)
    else $error("bad write response wrong");
  a_alloc_inval: assert property (                         // see RL11
    (acc_take && XIP_WRITE && XIP_ALIAS == ALIAS_CACHE_ALLOC) |-> CACHE_INVAL == en_q
    && !XIP_ERR)
    else $error("allocating write did not invalidate");
  a_bypass_off: assert property (                          // see RL12
    (acc_take && !XIP_WRITE && is_flash && !en_q) |-> FLASH_READ && !CACHE_LOOKUP)
    else $error("disabled cache still looked up");
  a_hit_skip: assert property (                            // see RL13
    (acc_take && !XIP_WRITE && is_cacheable && en_q && XIP_TAG_HIT) |-> !FLASH_READ)
    else $error("flash read on a cache hit");
  a_acc_count: assert property (                           // see RL3
    (acc_inc && !(wr_take && ofs == OFS_ACC_CNT) && acc_cnt != CNT_MAX)
    |=> acc_cnt == $past(acc_cnt) + CNT_W'(1))
    else $error("access not counted");
  a_hit_count: assert property (                           // see RL4
    (!hit && !(wr_take && ofs == OFS_HIT_CNT)) |=> hit_cnt == $past(hit_cnt))
    else $error("hit counter moved without a hit");
  a_unmapped: assert property (                            // see RL5
    (access_ph && !in_window) |-> PSLVERR && PREADY)
    else $error("unmapped access not refused");

endmodule

// [xcc_pkg.sv]
// xcc_pkg: register map, field layout, reset values and flush sizing for the
// execute-in-place cache control and counter block.
// assumes: one system clock; apb data 32 bits; byte addresses decoded whole.
package xcc_pkg;

  // ==========================================================================
  // register map
  localparam logic [31:0] XCC_BASE_ADDR    = 32'h1400_0000;
  localparam int          XCC_OFS_W        = 5;
  localparam logic [4:0]  OFS_CONTROL      = 5'h00;
  localparam logic [4:0]  OFS_INVALIDATE   = 5'h04;
  localparam logic [4:0]  OFS_STATUS       = 5'h08;
  localparam logic [4:0]  OFS_HIT_CNT      = 5'h0c;
  localparam logic [4:0]  OFS_ACC_CNT      = 5'h10;
  localparam logic [4:0]  OFS_STREAM_ADDR  = 5'h14;
  localparam logic [4:0]  OFS_STREAM_CNT   = 5'h18;
  localparam logic [4:0]  OFS_STREAM_QUEUE = 5'h1c;

  // ==========================================================================
  // control fields
  localparam int   CTL_EN_BIT       = 0;
  localparam int   CTL_BADWR_BIT    = 1;
  localparam int   CTL_PD_BIT       = 3;
  localparam logic CTL_EN_RST       = 1'b1;
  localparam logic CTL_BADWR_RST    = 1'b1;
  localparam logic CTL_PD_RST       = 1'b0;
  localparam int   INV_GO_BIT       = 0;
  localparam int   STS_READY_BIT    = 0;
  localparam int   STS_EMPTY_BIT    = 1;
  localparam int   STS_FULL_BIT     = 2;

  // ==========================================================================
  // stream fields
  localparam int          STREAM_ADDR_LSB  = 2;
  localparam int          STREAM_CNT_W     = 22;
  localparam logic [29:0] STREAM_ADDR_RST  = 30'h0000_0000;
  localparam logic [21:0] STREAM_CNT_RST   = 22'h00_0000;

  // ==========================================================================
  // counters
  localparam int          CNT_W   = 32;
  localparam logic [31:0] CNT_MAX = 32'hffff_ffff;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;

  // ==========================================================================
  // xip alias codes (address bits 26:24 of the xip window)
  localparam logic [2:0] ALIAS_CACHE_ALLOC   = 3'h0;
  localparam logic [2:0] ALIAS_CACHE_NOALLOC = 3'h1;
  localparam logic [2:0] ALIAS_NOCACHE_ALLOC = 3'h2;
  localparam logic [2:0] ALIAS_NOCACHE_NOAL  = 3'h3;
  localparam logic [2:0] ALIAS_SRAM          = 3'h5;

  // ==========================================================================
  // flush: one tag set cleared per cycle
  localparam int                FLUSH_SETS  = 1024;
  localparam int                FLUSH_IDX_W = $clog2(FLUSH_SETS);
  localparam logic [FLUSH_IDX_W-1:0] FLUSH_IDX_LAST = FLUSH_IDX_W'(FLUSH_SETS - 1);
  localparam logic [FLUSH_IDX_W-1:0] FLUSH_IDX_RST  = '0;

  typedef enum logic [1:0] {
    FL_IDLE  = 2'b00,
    FL_CLEAR = 2'b01,
    FL_DONE  = 2'b11
  } xcc_flush_t;

endpackage

// [xcc_sat_counter.sv]
// xcc_sat_counter: 32-bit event counter that sticks at all ones.
// assumes: inc and clr are single-cycle pulses on the same clock.
`timescale 1ns/1ps
module xcc_sat_counter
  import xcc_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // control
  input  wire logic             inc,
  input  wire logic             clr,
  // value
  output logic [CNT_W-1:0]      value
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // ==========================================================================
  // next value
  always_comb begin
    cnt_d = cnt_q;
    if (clr) begin
      cnt_d = inc ? CNT_W'(1) : CNT_RST;                  // see RL2
    end else if (inc && cnt_q != CNT_MAX) begin
      cnt_d = cnt_q + CNT_W'(1);                          // see RL1
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign value = cnt_q;

  // ==========================================================================
  // checks
  a_cnt_saturate: assert property (@(posedge clk) disable iff (!rst_n) // see RL1
    (cnt_q == CNT_MAX && !clr) |=> cnt_q == CNT_MAX)
    else $error("counter left its maximum without a clear");

  a_cnt_clear: assert property (@(posedge clk) disable iff (!rst_n) // see RL2
    (clr && !inc) |=> cnt_q == CNT_RST)
    else $error("counter not zero after a clear");

  a_cnt_step: assert property (@(posedge clk) disable iff (!rst_n) // see RL1
    (inc && !clr && cnt_q != CNT_MAX) |=> cnt_q == $past(cnt_q) + CNT_W'(1))
    else $error("counter did not step by one");

endmodule

// [xcc_xip_model.sv]
// xcc_xip_model: bus master plus tag ram answer in front of the xip port.
// assumes: bench calls access(); one clock; route is read settled before the accept edge.
`timescale 1ns/1ps
module xcc_xip_model (
  // clock
  input  wire logic       clk,
  // xip offer
  output logic            valid,
  output logic            wr,
  output logic [2:0]      alias_code,
  output logic            hit,
  input  wire logic       ready,
  // routing at accept: err, lookup, flash, inval, sram
  input  wire logic [4:0] route,
  output logic [4:0]      rec
);
  initial begin
    valid = 1'b0;
    wr = 1'b0;
    alias_code = 3'h7;
    hit = 1'b0;
    rec = 5'h00;
  end
  // offer held until ready at an edge; released lines show the inverse
  task automatic access(input logic w, input logic [2:0] a, input logic h);
    logic ok;
    @(posedge clk);
    valid <= 1'b1;
    wr <= w;
    alias_code <= a;
    hit <= h;
    // ready and route are read settled, ahead of the edge that takes the offer
    do begin
      @(negedge clk);
      ok = ready;
      rec = route;
      @(posedge clk);
    end while (ok !== 1'b1);
    valid <= 1'b0;
    wr <= ~w;
    alias_code <= ~a;
    hit <= ~h;
  endtask
endmodule

// [xcc_top_tb_top.sv]
// xcc_top_tb_top: apb register and xip routing tests for xcc_top.
// assumes: xcc_xip_model drives the xip port; stream inputs set here.
`timescale 1ns/1ps
module xcc_top_tb_top;
  import xcc_pkg::*;
  // ==========================================================
  // signals
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] paddr, pwdata, prdata, r, qdata, ssa;
  logic        xv, xw, xh, xr, xe, lk, iv, fr, sa, pd, qempty, qfull, tc, scw, qpop;
  logic [2:0]  xa;
  logic [4:0]  rec;
  logic [STREAM_CNT_W-1:0] swc;
  int          bad_count, n_compared, cyc, stall, npop, ncw;

  xcc_top uut (.CLK(clk), .RSTN(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .XIP_VALID(xv), .XIP_WRITE(xw),
    .XIP_ALIAS(xa), .XIP_TAG_HIT(xh), .XIP_READY(xr), .XIP_ERR(xe),
    .CACHE_LOOKUP(lk), .CACHE_INVAL(iv), .FLASH_READ(fr), .SRAM_ACCESS(sa),
    .MEM_POWER_DOWN(pd), .TAG_CLR_EN(tc), .TAG_CLR_INDEX(),
    .STREAM_START_ADDR(ssa), .STREAM_WORD_COUNT(swc), .STREAM_COUNT_WR(scw),
    .STREAM_QUEUE_POP(qpop), .STREAM_QUEUE_DATA(qdata),
    .STREAM_QUEUE_EMPTY(qempty), .STREAM_QUEUE_FULL(qfull));
  xcc_xip_model m (.clk(clk), .valid(xv), .wr(xw), .alias_code(xa), .hit(xh),
    .ready(xr), .route({xe, lk, fr, iv, sa}), .rec(rec));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // counts the stream strobes, read settled
  always @(negedge clk) begin
    if (scw === 1'b1) ncw++;
    if (qpop === 1'b1) npop++;
  end
  // cuts a hang short
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      results();
    end
  end

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    logic ok;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    stall = 0;
    // answer read settled, ahead of the edge that completes the access
    do begin
      @(negedge clk);
      ok = pready;
      r = prdata;
      e = pslverr;
      @(posedge clk);
      stall++;
    end while (ok !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] o, input logic [31:0] exp);
    apb(1'b0, XCC_BASE_ADDR + 32'(o), 32'h0000_0000);
    chk(r, exp);
  endtask
  task automatic wr(input logic [4:0] o, input logic [31:0] d);
    apb(1'b1, XCC_BASE_ADDR + 32'(o), d);
  endtask
  task automatic xp(input logic w, input logic [2:0] a, input logic h,
                    input logic [4:0] exp);
    m.access(w, a, h);
    chk(32'(rec), 32'(exp));
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // tests; expected route is {err, lookup, flash, inval, sram}
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {bad_count, n_compared, cyc, stall, npop, ncw} = '0;
    qdata = 32'hc3a5_0f96;
    qempty = 1'b1;
    qfull = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_STATUS, 32'h0000_0002);
    r = 32'h0000_0000;
    for (int i = 0; i < 600 && r[0] !== 1'b1; i++)
      apb(1'b0, XCC_BASE_ADDR + 32'(OFS_STATUS), 32'h0000_0000);
    chk(r, 32'h0000_0003);
    rd(OFS_CONTROL, 32'h0000_0003);
    rd(OFS_HIT_CNT, 32'h0000_0000);
    xp(1'b0, ALIAS_CACHE_ALLOC, 1'b1, 5'h08);
    xp(1'b0, ALIAS_CACHE_ALLOC, 1'b0, 5'h0c);
    xp(1'b0, ALIAS_NOCACHE_ALLOC, 1'b1, 5'h04);
    xp(1'b0, ALIAS_CACHE_NOALLOC, 1'b1, 5'h08);
    xp(1'b0, ALIAS_NOCACHE_NOAL, 1'b0, 5'h04);
    rd(OFS_ACC_CNT, 32'h0000_0005);
    rd(OFS_HIT_CNT, 32'h0000_0002);
    wr(OFS_HIT_CNT, 32'hffff_ffff);
    rd(OFS_HIT_CNT, 32'h0000_0000);
    rd(OFS_ACC_CNT, 32'h0000_0005);
    wr(OFS_ACC_CNT, 32'h0000_0000);
    rd(OFS_ACC_CNT, 32'h0000_0000);
    xp(1'b1, ALIAS_CACHE_ALLOC, 1'b1, 5'h02);
    xp(1'b1, ALIAS_CACHE_NOALLOC, 1'b0, 5'h10);
    wr(OFS_CONTROL, 32'h0000_0001);
    xp(1'b1, ALIAS_NOCACHE_NOAL, 1'b0, 5'h00);
    xp(1'b1, ALIAS_CACHE_ALLOC, 1'b1, 5'h02);
    xp(1'b0, ALIAS_SRAM, 1'b0, 5'h10);
    wr(OFS_CONTROL, 32'h0000_0000);
    xp(1'b0, ALIAS_CACHE_ALLOC, 1'b1, 5'h04);
    xp(1'b0, ALIAS_SRAM, 1'b0, 5'h01);
    rd(OFS_ACC_CNT, 32'h0000_0001);
    wr(OFS_CONTROL, 32'h0000_0009);
    rd(OFS_CONTROL, 32'h0000_0008);
    chk(32'(pd), 32'h0000_0001);
    xp(1'b0, ALIAS_SRAM, 1'b0, 5'h10);
    wr(OFS_INVALIDATE, 32'h0000_0001);
    rd(OFS_STATUS, 32'h0000_0002);
    chk(32'(tc), 32'h0000_0001);
    qempty <= 1'b0;
    qfull <= 1'b1;
    rd(OFS_INVALIDATE, 32'h0000_0000);
    chk(32'(stall > 1000), 32'h0000_0001);
    rd(OFS_STATUS, 32'h0000_0005);
    chk(32'(tc), 32'h0000_0000);
    apb(1'b0, XCC_BASE_ADDR + 32'h0000_0020, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    chk(r, 32'h0000_0000);
    wr(OFS_STREAM_ADDR, 32'h1234_5679);
    rd(OFS_STREAM_ADDR, 32'h1234_5678);
    chk(ssa, 32'h1234_5678);
    wr(OFS_STREAM_CNT, 32'hffc0_0005);
    rd(OFS_STREAM_CNT, 32'h0000_0005);
    chk(32'(swc), 32'h0000_0005);
    chk(32'(ncw), 32'h0000_0001);
    rd(OFS_STREAM_QUEUE, 32'hc3a5_0f96);
    chk(32'(npop), 32'h0000_0001);
    results();
  end
endmodule
